// File: inc/cs_pkg.sv
// shared constants and types for the conversion scheduler
`default_nettype none
package cs_pkg;
    typedef logic [7:0] cs_byte_t;
    typedef logic [2:0] cs_chan_t;
    typedef logic [1:0] cs_mode_t;

    // command bytes of the registers
    localparam cs_byte_t CMD_MAIN_CFG = 8'h03;
    localparam cs_byte_t CMD_INTERVAL = 8'h04;
    localparam cs_byte_t CMD_CHAN_EN  = 8'h05;
    localparam cs_byte_t CMD_FILTER   = 8'h06;
    localparam cs_byte_t CMD_TRIGGER  = 8'h0f;

    // field positions
    localparam int STANDBY_BIT = 6;
    localparam int R2_FILT_LSB = 2;
    localparam int R1_FILT_LSB = 0;
    localparam int FRAC_LSB    = 3;
    localparam int NUM_CHAN    = 5;

    // reset values
    localparam cs_mode_t   INTERVAL_RST = 2'h2;
    localparam logic [4:0] CHAN_EN_RST  = 5'h1f;
    localparam cs_mode_t   FILT_RST     = 2'h3;
    localparam logic       STANDBY_RST  = 1'b0;
    localparam cs_mode_t   QUEUE_EN_RST = 2'h3;

    // interval and filter codes
    localparam cs_mode_t IVL_CONT  = 2'h0;
    localparam cs_mode_t IVL_364MS = 2'h1;
    localparam cs_mode_t IVL_1S    = 2'h2;
    localparam cs_mode_t IVL_2500  = 2'h3;
    localparam cs_mode_t FILT_OFF  = 2'h0;

    // timing: 1 ms tick from the 50 ns clock, periods in ms
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_NS       = 1000000;
    localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PERIOD_364_MS = 364;
    localparam int PERIOD_1S_MS  = 1000;
    localparam int PERIOD_2S5_MS = 2500;
    localparam logic [11:0] TICKS_364 = 12'(PERIOD_364_MS);
    localparam logic [11:0] TICKS_1S  = 12'(PERIOD_1S_MS);
    localparam logic [11:0] TICKS_2S5 = 12'(PERIOD_2S5_MS);
endpackage
`default_nettype wire

// File: logic/cs_ms_divider.sv
// millisecond tick divider, restartable
`timescale 1ns/10ps
`default_nettype none
module cs_ms_divider #(
    parameter int TICK_CYCLES = 20000
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // control
    input  wire logic restart,
    output logic      tick
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic        wrap;

    // wrap at the last cycle of each millisecond
    assign wrap    = (cnt_ff == 16'(TICK_CYCLES - 1));
    assign nxt_cnt = (restart || wrap) ? 16'h0000 : cnt_ff + 16'h0001;
    assign tick    = wrap && !restart;

    // cycle counter
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 16'h0000;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // cs_ms_divider
`default_nettype wire

// File: logic/cs_period_timer.sv
// interval timer counting millisecond ticks against a limit
`timescale 1ns/10ps
`default_nettype none
module cs_period_timer (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // control
    input  wire logic        restart,
    input  wire logic        tick,
    input  wire logic [11:0] limit,
    // status
    output logic             done_ff
);
    logic [11:0] ms_ff;
    logic [11:0] nxt_ms;
    logic        nxt_done;

    // count saturates at the limit, restart clears
    assign nxt_ms   = restart ? 12'h000 : ((tick && ms_ff < limit) ? ms_ff + 12'h001 : ms_ff);
    assign nxt_done = !restart && (nxt_ms >= limit);

    // elapsed counter and flag
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ms_ff   <= 12'h000;
            done_ff <= 1'b0;
        end else begin
            ms_ff   <= nxt_ms;
            done_ff <= nxt_done;
        end
    end
endmodule // cs_period_timer
`default_nettype wire

// File: logic/cs_conversion_scheduler.sv
// conversion scheduler: interval, channel enables, filter select, one-shot trigger
//
// Contract
// RULE_01: interval code 00 continuous, 01 0.364 s, 10 1 s, 11 2.5 s; reset 1 s.
// RULE_02: interval field sets the period over which enabled channels are converted.
// RULE_03: enabled channels convert in turn, then idle until the interval has elapsed.
// RULE_04: a channel with its enable clear is skipped and gets no measurement.
// RULE_05: continuous mode repeats at once, so fewer channels means faster repetition.
// RULE_06: timed intervals pad idle time so the period stays fixed.
// RULE_07: enable bits local 0, remotes 1 to 4; one enables; all set at reset.
// RULE_08: filter bits 3:2 pick remote 2 filter: 00 off, 01 basic, 11 enhanced.
// RULE_09: filter bits 1:0 pick remote 1 filter, same coding; both enhanced at reset.
// RULE_10: software must never write code 10 into a filter field.
// RULE_11: any trigger write starts one sequence over enabled channels while in standby.
// RULE_12: trigger register is write-only; written data is dropped, nothing stored.
// RULE_13: config bit 6 set means standby, clear means periodic conversion.
// RULE_14: two fraction bits of a remote reading read zero while its filter is off.
// RULE_15: a trigger write while actively converting is ignored.
`timescale 1ns/10ps
`default_nettype none
module cs_conversion_scheduler #(
    parameter int TICK_CYCLES = cs_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic            sys_clk,
    input  wire logic            rst_b,
    // register port from the serial bus engine
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    input  wire cs_pkg::cs_byte_t reg_cmd,
    input  wire cs_pkg::cs_byte_t reg_wdata,
    output cs_pkg::cs_byte_t     reg_rdata_ff,
    // measurement front end
    output logic                 conv_start_ff,
    output cs_pkg::cs_chan_t     conv_chan_ff,
    input  wire logic            conv_done,
    output logic                 conv_busy,
    // filter control and remote fraction bytes
    output cs_pkg::cs_mode_t     remote1_filter_mode,
    output cs_pkg::cs_mode_t     remote2_filter_mode,
    input  wire cs_pkg::cs_byte_t remote1_lsb_raw,
    input  wire cs_pkg::cs_byte_t remote2_lsb_raw,
    output cs_pkg::cs_byte_t     remote1_lsb_ff,
    output cs_pkg::cs_byte_t     remote2_lsb_ff
);
    import cs_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_WAIT, ST_PAD} cs_state_e;

    cs_state_e   state_ff;
    cs_state_e   nxt_state;
    cs_chan_t    chan_ff;
    cs_chan_t    nxt_chan;
    cs_mode_t    interval_select;
    logic [4:0]  chan_en_ff;
    cs_mode_t    r1_filt_ff;
    cs_mode_t    r2_filt_ff;
    logic        standby_ctl;
    cs_mode_t    queue_en_ff;
    cs_byte_t    rd_mux;
    logic [11:0] period_limit;
    logic        ms_tick;
    logic        period_done;

    // register write decode
    logic wr_cfg;
    logic wr_ivl;
    logic wr_en;
    logic wr_filt;
    logic wr_trig;
    assign wr_cfg  = reg_wr && (reg_cmd == CMD_MAIN_CFG);
    assign wr_ivl  = reg_wr && (reg_cmd == CMD_INTERVAL);
    assign wr_en   = reg_wr && (reg_cmd == CMD_CHAN_EN);
    assign wr_filt = reg_wr && (reg_cmd == CMD_FILTER);
    assign wr_trig = reg_wr && (reg_cmd == CMD_TRIGGER);

    // sequencing terms
    // a trigger counts only while idle in standby, so one-shots never stack
    logic one_shot_go;
    logic seq_begin;
    logic chan_end;
    logic chan_hit;
    logic pad_over;
    assign one_shot_go = wr_trig && standby_ctl && (state_ff == ST_IDLE); // [RULE_11] [RULE_15]
    assign pad_over    = (interval_select == IVL_CONT) || period_done;     // [RULE_05] [RULE_06]
    assign seq_begin   = ((state_ff == ST_IDLE) && (!standby_ctl || one_shot_go))
                      || ((state_ff == ST_PAD) && !standby_ctl && pad_over);
    assign chan_end    = (chan_ff == 3'(NUM_CHAN));
    assign chan_hit    = !chan_end && chan_en_ff[chan_ff];                  // [RULE_04]
    assign conv_busy   = (state_ff == ST_SCAN) || (state_ff == ST_WAIT);

    // interval code to period length
    assign period_limit = (interval_select == IVL_364MS) ? TICKS_364 :     // [RULE_01]
                          (interval_select == IVL_1S)    ? TICKS_1S  :
                          (interval_select == IVL_2500)  ? TICKS_2S5 : 12'h000;

    // period timing restarts at the head of each sequence
    // shared restart keeps tick phase and period count aligned
    cs_ms_divider #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_div (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .restart (seq_begin),
        .tick    (ms_tick)
    );

    cs_period_timer u_timer (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .restart (seq_begin),
        .tick    (ms_tick),
        .limit   (period_limit),
        .done_ff (period_done)
    );

    // next state of the sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (seq_begin) begin
                    nxt_state = ST_SCAN;                           // [RULE_13]
                end
            end
            ST_SCAN: begin
                if (chan_end) begin
                    nxt_state = ST_PAD;                            // [RULE_03]
                end else if (chan_hit) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (conv_done) begin
                    nxt_state = ST_SCAN;
                end
            end
            ST_PAD: begin
                if (standby_ctl) begin
                    nxt_state = ST_IDLE;
                end else if (pad_over) begin
                    nxt_state = ST_SCAN;                           // [RULE_02] [RULE_06]
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // channel index walks 0..4, skipping disabled ones
    assign nxt_chan = seq_begin ? 3'h0 :
                      (((state_ff == ST_SCAN) && !chan_end && !chan_hit)
                       || ((state_ff == ST_WAIT) && conv_done)) ? chan_ff + 3'h1 : chan_ff;

    // sequencer registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
            chan_ff  <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            chan_ff  <= nxt_chan;
        end
    end

    // one start pulse per enabled channel
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_start_ff <= 1'b0;
            conv_chan_ff  <= 3'h0;
        end else begin
            conv_start_ff <= (state_ff == ST_SCAN) && chan_hit;   // [RULE_04]
            if ((state_ff == ST_SCAN) && chan_hit) begin
                conv_chan_ff <= chan_ff;
            end
        end
    end

    // configuration registers; trigger data is never stored
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            standby_ctl     <= STANDBY_RST;
            queue_en_ff     <= QUEUE_EN_RST;
            interval_select <= INTERVAL_RST;
            chan_en_ff      <= CHAN_EN_RST;
            r1_filt_ff      <= FILT_RST;
            r2_filt_ff      <= FILT_RST;
        end else begin
            if (wr_cfg) begin
                standby_ctl <= reg_wdata[STANDBY_BIT];                    // [RULE_13]
                queue_en_ff <= reg_wdata[1:0];
            end
            if (wr_ivl) begin
                interval_select <= reg_wdata[1:0];                        // [RULE_01]
            end
            if (wr_en) begin
                chan_en_ff <= reg_wdata[4:0];                             // [RULE_07]
            end
            if (wr_filt) begin
                r2_filt_ff <= reg_wdata[R2_FILT_LSB +: 2];                // [RULE_08]
                r1_filt_ff <= reg_wdata[R1_FILT_LSB +: 2];                // [RULE_09]
            end
        end
    end

    assign remote1_filter_mode = r1_filt_ff;
    assign remote2_filter_mode = r2_filt_ff;

    // read data: reserved bits zero, trigger and unmapped read zero
    assign rd_mux = (reg_cmd == CMD_MAIN_CFG) ? {1'b0, standby_ctl, 4'h0, queue_en_ff} :
                    (reg_cmd == CMD_INTERVAL) ? {6'h00, interval_select} :
                    (reg_cmd == CMD_CHAN_EN)  ? {3'h0, chan_en_ff} :
                    (reg_cmd == CMD_FILTER)   ? {4'h0, r2_filt_ff, r1_filt_ff} : 8'h00; // [RULE_12]

    // read data register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_ff <= rd_mux;
        end
    end

    // fraction masking for the two filtered remotes
    // reserved filter code 10 counts as filter on
    logic [1:0][7:0] lsb_raw;
    logic [7:0]      lsb_ff [2];
    logic [1:0][1:0] filt_mode;
    assign lsb_raw   = {remote2_lsb_raw, remote1_lsb_raw};
    assign filt_mode = {r2_filt_ff, r1_filt_ff};
    for (genvar g = 0; g < 2; g++) begin : g_frac
        logic [1:0] frac;
        assign frac = (filt_mode[g] == FILT_OFF) ? 2'h0 : lsb_raw[g][FRAC_LSB +: 2]; // [RULE_14]
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                lsb_ff[g] <= 8'h00;
            end else begin
                lsb_ff[g] <= {lsb_raw[g][7:5], frac, 3'h0};
            end
        end
    end
    assign remote1_lsb_ff = lsb_ff[0];
    assign remote2_lsb_ff = lsb_ff[1];

    // checks on the scheduler
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_interval_write: assert property (wr_ivl |=> interval_select == $past(reg_wdata[1:0])) // [RULE_01]
        else $error("interval field did not take the written code");

    a_enable_write: assert property (wr_en |=> chan_en_ff == $past(reg_wdata[4:0])) // [RULE_07]
        else $error("channel enables did not take the written value");

    a_filter_write: assert property (wr_filt |=> {r2_filt_ff, r1_filt_ff} == $past(reg_wdata[3:0])) // [RULE_08]
        else $error("filter fields did not take the written value");

    a_skip_disabled: assert property (conv_start_ff |-> chan_en_ff[conv_chan_ff] || $past(wr_en)) // [RULE_04]
        else $error("conversion started on a disabled channel");

    a_pad_holds: assert property ((state_ff == ST_PAD) && !standby_ctl && !pad_over // [RULE_06]
                                  |=> (state_ff == ST_PAD) && !conv_start_ff)
        else $error("sequence restarted before the period elapsed");

    a_cont_restart: assert property ((state_ff == ST_PAD) && !standby_ctl // [RULE_05]
                                     && (interval_select == IVL_CONT) |=> (state_ff == ST_SCAN) && (chan_ff == 3'h0))
        else $error("continuous mode did not restart at once");

    a_trigger_starts: assert property (one_shot_go && (chan_en_ff != 5'h00) && !wr_en // [RULE_11]
                                       |-> ##[2:7] conv_start_ff)
        else $error("trigger in standby started no conversion");

    a_trigger_ignored: assert property (wr_trig && !standby_ctl && (state_ff == ST_PAD) && !pad_over // [RULE_15]
                                        |=> (state_ff == ST_PAD) && !conv_start_ff)
        else $error("trigger accepted while converting");

    a_standby_stays: assert property (standby_ctl && (state_ff == ST_IDLE) && !wr_trig && !wr_cfg // [RULE_13]
                                      |=> state_ff == ST_IDLE)
        else $error("standby left idle without a trigger");

    a_trigger_reads_zero: assert property (reg_rd && (reg_cmd == CMD_TRIGGER) |=> reg_rdata_ff == 8'h00) // [RULE_12]
        else $error("trigger register read back nonzero");

    a_frac_masked: assert property ((r1_filt_ff == FILT_OFF) |=> remote1_lsb_ff[4:3] == 2'h0) // [RULE_14]
        else $error("remote 1 fraction bits set with filter off");

    a_wait_done: assert property ((state_ff == ST_WAIT) && !conv_done |=> state_ff == ST_WAIT) // [RULE_03]
        else $error("sequencer left a conversion before it finished");

    a_busy_start: assert property (conv_start_ff |-> conv_busy) // [RULE_03]
        else $error("start pulse seen outside a busy sequence");

    a_skip_step: assert property ((state_ff == ST_SCAN) && !chan_end && !chan_en_ff[chan_ff] // [RULE_04]
                                  |=> !conv_start_ff && (chan_ff == $past(chan_ff) + 3'h1))
        else $error("disabled channel was not skipped");

    a_standby_finish: assert property ((state_ff == ST_PAD) && standby_ctl |=> state_ff == ST_IDLE) // [RULE_13]
        else $error("standby did not stop after the sequence");

    a_frac_masked_r2: assert property ((r2_filt_ff == FILT_OFF) |=> remote2_lsb_ff[4:3] == 2'h0) // [RULE_14]
        else $error("remote 2 fraction bits set with filter off");
endmodule // cs_conversion_scheduler
`default_nettype wire

// File: sim/cs_conversion_scheduler_tb.sv
// self-checking bench for the conversion scheduler
`timescale 1ns/10ps
`default_nettype none
module cs_conversion_scheduler_tb;
    import cs_pkg::*;
    localparam int TB_TICK = 4;
    // design ports
    logic     sys_clk         = 1'b0;
    logic     rst_b           = 1'b0;
    logic     reg_wr          = 1'b0;
    logic     reg_rd          = 1'b0;
    cs_byte_t reg_cmd         = 8'h00;
    cs_byte_t reg_wdata       = 8'h00;
    logic     conv_done       = 1'b0;
    cs_byte_t remote1_lsb_raw = 8'h00;
    cs_byte_t remote2_lsb_raw = 8'h00;
    cs_byte_t reg_rdata_ff, remote1_lsb_ff, remote2_lsb_ff;
    logic     conv_start_ff, conv_busy;
    cs_chan_t conv_chan_ff;
    cs_mode_t remote1_filter_mode, remote2_filter_mode;
    // bench state
    int       err_total = 0;
    int       n_tests   = 0;
    int       cyc       = 0;
    int       done_wait = 0;
    int       g_full, g_one, g;
    cs_chan_t ch_q[$];
    int       t_q[$];
    cs_byte_t d, r1, r2;
    cs_mode_t fc[3]     = '{2'h0, 2'h1, 2'h3}; // reserved code 10 never used
    cs_byte_t cmds[6]   = '{CMD_MAIN_CFG, CMD_INTERVAL, CMD_CHAN_EN, CMD_FILTER, CMD_TRIGGER, 8'h20};
    cs_byte_t rst_v[6]  = '{8'h03, 8'h02, 8'h1f, 8'h0f, 8'h00, 8'h00};
    cs_byte_t keep[6]   = '{8'h43, 8'h03, 8'h1f, 8'h0f, 8'h00, 8'h00};

    // clock
    always #25 sys_clk = ~sys_clk;

    cs_conversion_scheduler #(.TICK_CYCLES(TB_TICK)) cs_conversion_scheduler_i (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd),
        .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .conv_start_ff(conv_start_ff),
        .conv_chan_ff(conv_chan_ff), .conv_done(conv_done), .conv_busy(conv_busy),
        .remote1_filter_mode(remote1_filter_mode), .remote2_filter_mode(remote2_filter_mode),
        .remote1_lsb_raw(remote1_lsb_raw), .remote2_lsb_raw(remote2_lsb_raw),
        .remote1_lsb_ff(remote1_lsb_ff), .remote2_lsb_ff(remote2_lsb_ff));

    // front end stand-in: log each start, answer 2 to 5 cycles later
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        conv_done <= (conv_start_ff !== 1'b1) && (done_wait == 1);
        if (conv_start_ff === 1'b1) begin
            chk_byte("busy at start", 8'h01, {7'h0, conv_busy});
            ch_q.push_back(conv_chan_ff);
            t_q.push_back(cyc);
            done_wait <= 1 + ($urandom % 4);
        end else if (done_wait > 0) begin
            done_wait <= done_wait - 1;
        end
    end

    task automatic chk_byte(input string what, input cs_byte_t exp, input cs_byte_t got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_near(input string what, input int exp, input int got, input int tol);
        n_tests++;
        if (got < exp - tol || got > exp + tol) begin
            err_total++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic reg_write(input cs_byte_t cmd, input cs_byte_t data);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_cmd <= cmd;
        reg_wdata <= data;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input cs_byte_t cmd, output cs_byte_t data);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_cmd <= cmd;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        data = reg_rdata_ff;
    endtask

    // fraction byte as the filter setting allows it to read
    function automatic cs_byte_t frac(input cs_byte_t raw, input cs_mode_t mode);
        return (raw & 8'he0) | ((mode == 2'h0) ? 8'h00 : (raw & 8'h18));
    endfunction

    function automatic int per_cyc(input cs_mode_t ivl);
        return (ivl == 2'h1) ? 364 * TB_TICK : (ivl == 2'h2) ? 1000 * TB_TICK : 2500 * TB_TICK;
    endfunction

    // wait for a start of channel first, keep only that entry
    task automatic wait_first(input int first);
        int n;
        int t;
        n = 0;
        ch_q.delete();
        t_q.delete();
        while (!(ch_q.size() > 0 && ch_q[$] == first) && n < 12000) begin
            @(negedge sys_clk);
            n++;
        end
        chk_near("start wait", 0, int'(n >= 12000), 0);
        t = (t_q.size() > 0) ? t_q[$] : 0;
        ch_q.delete();
        t_q.delete();
        ch_q.push_back(cs_chan_t'(first));
        t_q.push_back(t);
    endtask

    // program rate and enables, then check order and, for timed intervals, repetition time
    task automatic run_rate(input cs_mode_t ivl, input logic [4:0] mask, output int gap);
        int en[$];
        int firsts[$];
        for (int c = 0; c < NUM_CHAN; c++) if (mask[c]) en.push_back(c);
        reg_write(CMD_CHAN_EN, {3'h0, mask});
        reg_write(CMD_INTERVAL, {6'h0, ivl});
        wait_first(en[0]);
        wait_first(en[0]);
        repeat ((ivl == IVL_CONT) ? 200 : per_cyc(ivl) + 200) @(negedge sys_clk);
        foreach (ch_q[i]) begin
            chk_byte("channel", 8'(en[i % en.size()]), {5'h0, ch_q[i]});
            if (ch_q[i] == en[0]) firsts.push_back(t_q[i]);
        end
        gap = (firsts.size() > 1) ? (firsts[$] - firsts[0]) / (firsts.size() - 1) : 0;
        if (ivl != IVL_CONT) chk_near("period", per_cyc(ivl), gap, TB_TICK + 4);
    endtask

    task automatic print_verdict();
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #(85000 * 50);
        err_total++;
        $display("Error watchdog expected finish seen timeout");
        print_verdict();
    end

    // main sequence
    initial begin
        void'($urandom(32'h33d8e495));
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            reg_read(cmds[k], d);
            chk_byte("reset value", rst_v[k], d);
        end
        for (int k = 0; k < 6; k++) begin
            r1 = 8'($urandom);
            if (k == 3) r1 = {4'(r1), fc[$urandom % 3], fc[$urandom % 3]};
            reg_write(cmds[k], r1);
            reg_read(cmds[k], d);
            chk_byte("readback", r1 & keep[k], d);
        end
        reg_write(CMD_MAIN_CFG, 8'h00);
        for (int i = 0; i < 3; i++) begin
            reg_write(CMD_FILTER, {4'h0, fc[(i + 1) % 3], fc[i]});
            r1 = 8'($urandom);
            r2 = 8'($urandom);
            @(posedge sys_clk);
            remote1_lsb_raw <= r1;
            remote2_lsb_raw <= r2;
            @(posedge sys_clk);
            @(negedge sys_clk);
            chk_byte("r1 mode", {6'h0, fc[i]}, {6'h0, remote1_filter_mode});
            chk_byte("r2 mode", {6'h0, fc[(i + 1) % 3]}, {6'h0, remote2_filter_mode});
            chk_byte("r1 frac", frac(r1, fc[i]), remote1_lsb_ff);
            chk_byte("r2 frac", frac(r2, fc[(i + 1) % 3]), remote2_lsb_ff);
        end
        run_rate(IVL_CONT, 5'h1f, g_full);
        run_rate(IVL_CONT, 5'h01, g_one);
        chk_near("cont shrink", 1, int'(g_one < g_full && g_one > 0), 0);
        run_rate(IVL_364MS, 5'h1f, g);
        run_rate(IVL_364MS, 5'h05, g);
        run_rate(IVL_1S, 5'h12, g);
        run_rate(IVL_2500, 5'h18, g);
        // standby: no periodic work, one sequence per trigger write
        reg_write(CMD_INTERVAL, 8'h00);
        reg_write(CMD_MAIN_CFG, 8'h40);
        repeat (300) @(negedge sys_clk);
        ch_q.delete();
        repeat (2000) @(negedge sys_clk);
        chk_near("standby starts", 0, ch_q.size(), 0);
        chk_byte("busy idle", 8'h00, {7'h0, conv_busy});
        for (int m = 0; m < 2; m++) begin
            reg_write(CMD_CHAN_EN, (m == 0) ? 8'h1f : 8'h0a);
            ch_q.delete();
            reg_write(CMD_TRIGGER, 8'($urandom));
            repeat (300) @(negedge sys_clk);
            chk_near("one-shot count", (m == 0) ? 5 : 2, ch_q.size(), 0);
            foreach (ch_q[i]) chk_byte("one-shot chan", (m == 0) ? 8'(i) : 8'(2 * i + 1), {5'h0, ch_q[i]});
        end
        reg_read(CMD_TRIGGER, d);
        chk_byte("trigger read", 8'h00, d);
        // active: trigger write must not add a sequence
        reg_write(CMD_CHAN_EN, 8'h1f);
        reg_write(CMD_INTERVAL, {6'h0, IVL_2500});
        reg_write(CMD_MAIN_CFG, 8'h00);
        wait_first(0);
        repeat (300) @(negedge sys_clk);
        ch_q.delete();
        reg_write(CMD_TRIGGER, 8'($urandom));
        repeat (1000) @(negedge sys_clk);
        chk_near("active trigger", 0, ch_q.size(), 0);
        print_verdict();
    end
endmodule // cs_conversion_scheduler_tb
`default_nettype wire
